/* File: common/pvs_params.svh */
`ifndef PVS_PARAMS_SVH
`define PVS_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define PVS_ADDR_CTRL       8'h74
`define PVS_ADDR_GAIN       8'h75
`define PVS_CTRL_RESET      8'h00
`define PVS_GAIN_RESET      7'h00
`define PVS_GAIN_MAX        7'h7e
`define PVS_GAIN_RSVD       7'h7f
`define PVS_SAR_FIRST_TRIAL 7'h40

// ****************************************
// Control field positions
// ****************************************
`define PVS_BIT_PIN_EN      7
`define PVS_BIT_CLK_SEL     6
`define PVS_HYST_MSB        5
`define PVS_HYST_LSB        4
`define PVS_BIT_RSVD        3
`define PVS_RATE_MSB        2
`define PVS_RATE_LSB        0

// ****************************************
// Timing
// ****************************************
`define PVS_MCLK_NOM_HZ        64'd12000000
`define PVS_BASE_RATE_MILLIHZ  64'd15625
`define PVS_BASE_DIV           ((`PVS_MCLK_NOM_HZ * 64'd1000) / `PVS_BASE_RATE_MILLIHZ)
`define PVS_SETTLE_CYCLES      4

`endif

/* File: common/pvs_pkg.sv */
package pvs_pkg;

  typedef enum logic [1:0] {
    PVS_HYST_NONE = 2'b00,
    PVS_HYST_ONE  = 2'b01,
    PVS_HYST_TWO  = 2'b10,
    PVS_HYST_RSVD = 2'b11
  } pvs_hyst_type;

  typedef struct packed {
    logic         pin_en;
    logic         clk_mclk;
    pvs_hyst_type hyst;
    logic         rsvd;
    logic [2:0]   rate;
  } pvs_ctrl_type;

  typedef enum logic [1:0] {
    PVS_SAR_IDLE   = 2'b00,
    PVS_SAR_SETTLE = 2'b01,
    PVS_SAR_DECIDE = 2'b10
  } pvs_sar_state_type;

  typedef struct packed {
    logic       valid;
    logic [6:0] code;
  } pvs_conv_type;

endpackage

/* File: src/pvs_sar.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pvs_params.svh"

module pvs_sar
  import pvs_pkg::*;
#(
  parameter int SETTLE = `PVS_SETTLE_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   ce,
  input  wire logic   en,
  input  wire logic   start,
  input  wire logic   cmp_above,
  output logic [6:0]  trial,
  output logic        busy,
  output pvs_conv_type result
);

  pvs_sar_state_type st_q, st_d;
  logic [2:0]        bit_q, bit_d;
  logic [6:0]        trial_q, trial_d;
  logic [3:0]        settle_q, settle_d;
  pvs_conv_type      res_q, res_d;
  logic [6:0]        kept;

  // ****************************************
  // Bit-by-bit approximation
  // ****************************************
  // Each trial waits SETTLE cycles so the synchronised comparator has caught up.
  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    trial_d  = trial_q;
    settle_d = settle_q;
    res_d    = '{valid: 1'b0, code: res_q.code};
    kept     = trial_q;
    if (!en) begin
      st_d    = PVS_SAR_IDLE;
      trial_d = 7'h00;
    end else begin
      case (st_q)
        PVS_SAR_IDLE: begin
          if (start) begin
            trial_d  = `PVS_SAR_FIRST_TRIAL;
            bit_d    = 3'd6;
            settle_d = 4'(SETTLE - 1);
            st_d     = PVS_SAR_SETTLE;
          end
        end
        PVS_SAR_SETTLE: begin
          if (settle_q == 4'd0) begin
            st_d = PVS_SAR_DECIDE;
          end else begin
            settle_d = settle_q - 4'd1;
          end
        end
        PVS_SAR_DECIDE: begin
          if (!cmp_above) begin
            kept[bit_q] = 1'b0;
          end
          if (bit_q == 3'd0) begin
            res_d   = '{valid: 1'b1, code: kept};
            trial_d = kept;
            st_d    = PVS_SAR_IDLE;
          end else begin
            kept[bit_q - 3'd1] = 1'b1;
            trial_d  = kept;
            bit_d    = bit_q - 3'd1;
            settle_d = 4'(SETTLE - 1);
            st_d     = PVS_SAR_SETTLE;
          end
        end
        default: st_d = PVS_SAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q     <= PVS_SAR_IDLE;
      bit_q    <= 3'd0;
      trial_q  <= 7'h00;
      settle_q <= 4'd0;
      res_q    <= '0;
    end else if (ce) begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      trial_q  <= trial_d;
      settle_q <= settle_d;
      res_q    <= res_d;
    end
  end

  assign trial  = trial_q;
  assign busy   = (st_q != PVS_SAR_IDLE);
  assign result = res_q;

  a_sar_first_trial: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    (ce && en && start && st_q == PVS_SAR_IDLE) |=> (trial_q == `PVS_SAR_FIRST_TRIAL))
    else $error("conversion did not start at mid-scale");

  // A frozen clock enable holds the strobe, so only a freshly registered strobe is judged.
  a_sar_done_idle: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    (res_q.valid && $past(ce)) |-> (st_q == PVS_SAR_IDLE && !$past(res_q.valid)))
    else $error("result strobe not a single pulse at the end of a conversion");

endmodule // pvs_sar

`default_nettype wire

/* File: src/pvs_top.sv */
// Overview of operation
// RULE1: Control bit 7 selects pin volume; cleared keeps register volume and converter off.
// RULE2: Control bit 6 picks converter clock: 0 internal oscillator, 1 master clock.
// RULE3: Hysteresis field: none, plus/minus one, plus/minus two codes; 11 never written.
// RULE4: Three-bit rate field: 15.625 Hz at code 000, doubling to 2 kHz at 111.
// RULE5: On the internal oscillator the same divisors apply, so rates scale with it.
// RULE6: Gain readback is 7 bits: 0 means 18 dB, 0.5 dB per step down.
// RULE7: From code 0x5b steps are 1 dB down to -63 dB; code 0x7f reserved.
// RULE8: Software writes only zero to the top bit of the gain readback register.
// RULE9: Software writes only the reset value to reserved control bit 3.
// RULE10: Pin mode updates the gain once per sample and drives the playback volume.
`timescale 1ns/1ns
`default_nettype none
`include "pvs_params.svh"

module pvs_top
  import pvs_pkg::*;
#(
  parameter int BASE_DIV = int'(`PVS_BASE_DIV),
  parameter int SETTLE   = `PVS_SETTLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        rc_osc_tick,
  input  wire logic        mclk_tick,
  input  wire logic        pin_cmp_above,
  output logic      [6:0]  sar_trial,
  output logic             adc_pwr_en,
  output logic             adc_clk_mclk,
  input  wire logic [6:0]  reg_volume,
  output logic      [6:0]  dac_volume,
  output logic             dac_volume_from_pin
);

  // ****************************************
  // Comparator synchroniser
  // ****************************************
  // The comparator is analogue and asynchronous; a new level counts only once
  // the second and third stages agree, which also rejects single-cycle glitches.
  logic sync1_q, sync2_q, sync3_q, cmp_q, cmp_d;

  always_comb begin
    cmp_d = (sync2_q == sync3_q) ? sync3_q : cmp_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      cmp_q   <= 1'b0;
    end else if (ce) begin
      sync1_q <= pin_cmp_above;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      cmp_q   <= cmp_d;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  pvs_ctrl_type ctrl_q, ctrl_d;
  logic [6:0]   gain_q, gain_d;
  logic [7:0]   rdata_q, rdata_d;
  logic         first_q, first_d;
  logic [6:0]   dvol_q, dvol_d;
  logic [19:0]  div_q, div_d;
  logic         start_q, start_d;
  logic         sar_busy;
  pvs_conv_type conv;
  logic [6:0]   clipped;
  logic [6:0]   diff;
  logic [6:0]   hyst_span;
  logic         accept;
  logic         src_tick;
  logic [19:0]  div_limit;

  function automatic logic [6:0] hyst_width(input pvs_hyst_type h);
    case (h)
      PVS_HYST_NONE: hyst_width = 7'd0;
      PVS_HYST_ONE:  hyst_width = 7'd1;
      default:       hyst_width = 7'd2;
    endcase
  endfunction

  // Control writes store every bit, including the reserved bit 3, so that a
  // read returns what software wrote. Writes to the gain readback are dropped.
  always_comb begin
    ctrl_d = ctrl_q;
    if (reg_wr && reg_addr == `PVS_ADDR_CTRL) begin
      ctrl_d = pvs_ctrl_type'(reg_wdata); // RULE9
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `PVS_ADDR_CTRL: rdata_d = 8'(ctrl_q);
        `PVS_ADDR_GAIN: rdata_d = {1'b0, gain_q}; // RULE6 RULE8
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Sample-rate divider
  // ****************************************
  // Both clock sources use the same divisor, so oscillator rates track its
  // actual frequency.
  always_comb begin
    src_tick  = ctrl_q.clk_mclk ? mclk_tick : rc_osc_tick; // RULE2 RULE5
    div_limit = 20'(BASE_DIV >> ctrl_q.rate) - 20'd1; // RULE4
    div_d     = div_q;
    start_d   = 1'b0;
    if (!ctrl_q.pin_en) begin
      div_d = 20'd0; // RULE1
    end else if (src_tick) begin
      if (div_q >= div_limit) begin
        div_d   = 20'd0;
        start_d = !sar_busy;
      end else begin
        div_d = div_q + 20'd1;
      end
    end
  end

  // ****************************************
  // Gain update with hysteresis
  // ****************************************
  always_comb begin
    clipped   = (conv.code == `PVS_GAIN_RSVD) ? `PVS_GAIN_MAX : conv.code; // RULE7
    diff      = (clipped > gain_q) ? (clipped - gain_q) : (gain_q - clipped);
    hyst_span = hyst_width(ctrl_q.hyst); // RULE3
    accept    = conv.valid && (first_q || diff > hyst_span);
    gain_d    = accept ? clipped : gain_q; // RULE10
    first_d   = first_q;
    if (!ctrl_q.pin_en) begin
      first_d = 1'b1;
    end else if (conv.valid) begin
      first_d = 1'b0;
    end
    dvol_d = ctrl_q.pin_en ? gain_q : reg_volume; // RULE1 RULE10
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q  <= pvs_ctrl_type'(`PVS_CTRL_RESET);
      gain_q  <= `PVS_GAIN_RESET;
      rdata_q <= 8'h00;
      first_q <= 1'b1;
      dvol_q  <= 7'h00;
      div_q   <= 20'h0_0000;
      start_q <= 1'b0;
    end else if (ce) begin
      ctrl_q  <= ctrl_d;
      gain_q  <= gain_d;
      rdata_q <= rdata_d;
      first_q <= first_d;
      dvol_q  <= dvol_d;
      div_q   <= div_d;
      start_q <= start_d;
    end
  end

  pvs_sar #(
    .SETTLE (SETTLE)
  ) u_sar (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .en        (ctrl_q.pin_en),
    .start     (start_q),
    .cmp_above (cmp_q),
    .trial     (sar_trial),
    .busy      (sar_busy),
    .result    (conv)
  );

  assign reg_rdata           = rdata_q;
  assign adc_pwr_en          = ctrl_q.pin_en; // RULE1
  assign adc_clk_mclk        = ctrl_q.clk_mclk; // RULE2
  assign dac_volume          = dvol_q;
  assign dac_volume_from_pin = ctrl_q.pin_en;

  // ****************************************
  // Checks
  // ****************************************
  a_pwr_follows_write: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    (ce && reg_wr && reg_addr == `PVS_ADDR_CTRL) |=> (adc_pwr_en == $past(reg_wdata[7])))
    else $error("converter power does not follow control bit 7");

  a_clk_sel_write: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    (ce && reg_wr && reg_addr == `PVS_ADDR_CTRL) |=> (adc_clk_mclk == $past(reg_wdata[6])))
    else $error("converter clock select does not follow control bit 6");

  a_off_sar_idle: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    (ce && !ctrl_q.pin_en) |=> ##1 !sar_busy)
    else $error("converter active while pin volume is off");

  a_hyst_holds_gain: assert property (@(posedge clk) disable iff (!rstn) // RULE3
    (ce && conv.valid && !first_q && diff <= hyst_width(ctrl_q.hyst)) |=> $stable(gain_q))
    else $error("gain moved inside the hysteresis band");

  a_gain_takes_sample: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    (ce && conv.valid && diff > hyst_width(ctrl_q.hyst)) |=> (gain_q == $past(clipped)))
    else $error("gain not updated from a sample outside the band");

  a_gain_never_rsvd: assert property (@(posedge clk) disable iff (!rstn) // RULE7
    gain_q != `PVS_GAIN_RSVD)
    else $error("reserved gain code reached the readback");

  a_gain_readback: assert property (@(posedge clk) disable iff (!rstn) // RULE6
    (ce && reg_rd && reg_addr == `PVS_ADDR_GAIN) |=> (reg_rdata == {1'b0, $past(gain_q)}))
    else $error("gain readback mismatch");

  a_volume_source: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    (ce && ctrl_q.pin_en && $stable(ctrl_q)) ##1 ce |-> (dac_volume == $past(gain_q)))
    else $error("playback volume not taken from the pin gain");

endmodule // pvs_top

`default_nettype wire

/* File: testbench/pvs_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Analogue level on the volume_detect_pin
// ****************************************
// The level is held as the code it equals. The comparator answers at once,
// which is the fastest answer the converter has to cope with.
module pvs_pin_model (
  input  wire logic [6:0] trial,
  input  wire logic [6:0] level,
  output logic            above
);
  assign above = (level >= trial);
endmodule // pvs_pin_model

`default_nettype wire

/* File: testbench/pin_volume_sar_control_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_volume_sar_control_tb_top;
  localparam int BDIV = 1024;
  localparam int RC_P = 16;
  localparam int MC_P = 8;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       ce = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rdata;
  logic       rc_tick = 1'b0;
  logic       mc_tick = 1'b0;
  logic       cmp;
  logic [6:0] trial;
  logic [6:0] level = 7'h00;
  logic [6:0] reg_vol = 7'h30;
  logic [6:0] dvol;
  logic [6:0] prev_trial = 7'h00;
  logic       pwr;
  logic       csel;
  logic       from_pin;
  int         mismatches = 0;
  int         checked = 0;
  int         cyc = 0;
  int         starts = 0;
  int         last_start = 0;

  pvs_top #(.BASE_DIV(BDIV), .SETTLE(4)) u_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
    .rc_osc_tick(rc_tick), .mclk_tick(mc_tick), .pin_cmp_above(cmp),
    .sar_trial(trial), .adc_pwr_en(pwr), .adc_clk_mclk(csel),
    .reg_volume(reg_vol), .dac_volume(dvol), .dac_volume_from_pin(from_pin));

  pvs_pin_model u_pin (.trial(trial), .level(level), .above(cmp));

  always #50 clk = ~clk;

  // The two tick rates differ so that a wrong clock choice shows in the period.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rc_tick <= (cyc % RC_P == RC_P - 1);
    mc_tick <= (cyc % MC_P == MC_P - 1);
  end

  // A conversion start is seen as the trial code stepping onto its first value.
  always @(negedge clk) begin
    if (trial === 7'h40 && prev_trial !== 7'h40) begin
      starts++;
      last_start = cyc;
    end
    prev_trial = trial;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_int(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      mismatches++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 check(rdata, exp, what);
  endtask

  task automatic wait_start;
    int n;
    n = starts;
    for (int i = 0; i < 3000 && starts == n; i++) @(negedge clk);
  endtask

  task automatic period_chk(input int exp, input string what);
    int t0;
    wait_start;
    wait_start;
    t0 = last_start;
    wait_start;
    check_int(last_start - t0, exp, what);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_regs;
    @(posedge clk);
    #1 check({1'b0, dvol}, {1'b0, reg_vol}, "volume after reset");
    check({6'h00, pwr, from_pin}, 8'h00, "pin mode after reset");
    rd_chk(8'h74, 8'h00, "control reset");
    rd_chk(8'h75, 8'h00, "gain reset");
    wr(8'h75, 8'h55);
    rd_chk(8'h75, 8'h00, "gain after write");
    rd_chk(8'h76, 8'h00, "unmapped read");
  endtask

  task automatic t_pin_gain;
    level <= 7'h24;
    wr(8'h74, 8'h87);
    repeat (300) @(posedge clk);
    rd_chk(8'h75, 8'h24, "gain at 0 dB");
    check({1'b0, dvol}, 8'h24, "applied volume");
    check({6'h00, pwr, from_pin}, 8'h03, "pin mode on");
    check({7'h00, csel}, 8'h00, "oscillator clock");
  endtask

  // Hysteresis 11 is never written; the reserved bit 3 always stays 0.
  task automatic t_gain_table;
    logic [7:0] ctl [7] = '{8'h87, 8'h97, 8'h97, 8'ha7, 8'ha7, 8'h87, 8'h87};
    logic [6:0] lvl [7] = '{7'h25, 7'h26, 7'h27, 7'h29, 7'h2a, 7'h7f, 7'h5b};
    logic [7:0] exp [7] = '{8'h25, 8'h25, 8'h27, 8'h27, 8'h2a, 8'h7e, 8'h5b};
    for (int i = 0; i < 7; i++) begin
      wr(8'h74, ctl[i]);
      level <= lvl[i];
      repeat (300) @(posedge clk);
      rd_chk(8'h75, exp[i], "gain step");
    end
    wr(8'h74, 8'ha7);
    rd_chk(8'h74, 8'ha7, "control readback");
  endtask

  task automatic t_rates;
    level <= 7'h10;
    wr(8'h74, 8'h87);
    period_chk((BDIV >> 7) * RC_P, "period rate 7 osc");
    wr(8'h74, 8'h86);
    period_chk((BDIV >> 6) * RC_P, "period rate 6 osc");
    wr(8'h74, 8'hc7);
    period_chk((BDIV >> 7) * MC_P, "period rate 7 master");
    check({7'h00, csel}, 8'h01, "master clock select");
  endtask

  task automatic t_disable;
    int n;
    wr(8'h74, 8'h47);
    repeat (4) @(posedge clk);
    #1 check({1'b0, dvol}, 8'h30, "register volume back");
    check({6'h00, pwr, from_pin}, 8'h00, "pin mode off");
    n = starts;
    repeat (300) @(posedge clk);
    check_int(starts, n, "conversions while off");
    reg_vol <= 7'h11;
    repeat (3) @(posedge clk);
    #1 check({1'b0, dvol}, 8'h11, "register volume follows");
  endtask

  // A write made while the clock enable is low must not be taken.
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h74, 8'h47);
    repeat (2) @(posedge clk);
    #1 check({6'h00, pwr, from_pin}, 8'h03, "control frozen by ce");
    @(posedge clk);
    ce <= 1'b1;
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset_regs;
    t_pin_gain;
    t_gain_table;
    t_rates;
    t_freeze;
    t_disable;
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
endmodule // pin_volume_sar_control_tb_top

`default_nettype wire
